/* tb.sv */
// Self-checking bench for the transmit input port.
`timescale 1ns/1ns
module tb;
  logic mclk_i = 0, rst_b_i = 0, ce = 0, sy = 0, go = 0, bg = 0, es;
  logic [3:0] lc, kf, lv;
  logic [31:0] tw;
  logic [39:0] sd = '0, sw, rs;
  int error_cnt = 0, checks_done = 0, ea, eb, pa, pb;
  always #25 mclk_i = ~mclk_i;
  always @(lc[0]) ea++;
  always @(lc[1]) eb++;
  always @(posedge mclk_i) begin pa += int'(lv[0] === 1'b1); pb += int'(lv[1] === 1'b1); end
  xti_tx_port xti_tx_port_i (.mclk_i, .rst_b_i, .coding_enable_i(ce), .lane_sync_select_i(sy),
    .lane_tx_clock_i(lc), .lane_tx_sym_i(sw), .tx_word_o(tw), .control_char_flag_o(kf),
    .raw_sym_o(rs), .encode_sel_o(es), .lane_valid_o(lv));
  xti_mac_model xti_mac_model_i (.run_i(go), .b_i(bg), .sym_i(sd), .clk_o(lc), .sym_o(sw));
  task automatic chk(string n, logic [39:0] g, e);
    checks_done++;
    if (g !== e) begin error_cnt++; $display("ERROR %s expected %h seen %h", n, e, g); end
  endtask : chk
  task automatic complete_run;
    $display("%0d checks, %0d errors", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic burst(logic c, s, b, logic [39:0] v, r, logic [35:0] w);
    ce <= c; sy <= s; bg <= b; sd <= v;
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i); ea = 0; eb = 0; pa = 0; pb = 0;
    @(posedge mclk_i) go <= 1'b1;
    repeat (40) @(posedge mclk_i);
    go <= 1'b0;
    repeat (20) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("lane A count", 40'(pa), 40'(ea));
    chk("lane B count", 40'(pb), 40'(s ? ea : b ? eb : 0));
    chk("word and flags", 40'({kf, tw}), 40'(w));
    chk("raw symbols", rs, r);
    chk("encode select", 40'(es), 40'(c));
    $display("test done");
  endtask : burst
  task automatic t1; burst(1'b1, 1'b0, 1'b0, {10'h2f1, 10'h0c7, 10'h1b3, 10'h35a}, '0, 36'h10000005a); endtask : t1
  task automatic t2; burst(1'b0, 1'b1, 1'b0, {10'h3c1, 10'h2a7, 10'h155, 10'h2e8}, {10'h3c1, 10'h2a7, 10'h155, 10'h2e8},
    36'h10000005a); endtask : t2
  task automatic t3; burst(1'b1, 1'b0, 1'b1, {10'h31e, 10'h044, 10'h3b9, 10'h281}, {10'h3c1, 10'h2a7, 10'h155, 10'h2e8},
    36'ha1e44b981); endtask : t3
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    t1; t2; t3; complete_run;
  end
  initial begin #50000; error_cnt++; complete_run; end
endmodule : tb

/* xti_mac_model.sv */
// Far-side model driving the lane clocks and lane symbols.
`timescale 1ns/1ns
module xti_mac_model (input wire logic run_i, b_i, input wire logic [39:0] sym_i,
  output logic [3:0] clk_o, output logic [39:0] sym_o);
  logic on;
  initial begin
    clk_o = '0;
    sym_o = '0;
    #10;
    forever begin
      on = run_i;
      sym_o = on ? sym_i : ~sym_o; // Idle lines toggle so stale data never matches
      #100 clk_o ^= {{3{on & b_i}}, on};
      #100;
    end
  end
endmodule : xti_mac_model

/* xti_pkg.sv */
// Package of constants for the parallel transmit input port.
package xti_pkg;
  localparam int LANES      = 4;
  localparam int BYTE_W     = 8;
  localparam int SYM_W      = 10;
  localparam int SYNC_DEPTH = 2;
  localparam int BIT_NINTH  = 8;
  localparam int BIT_TENTH  = 9;
  localparam int WORD_W     = LANES * BYTE_W;
  localparam int CLK_PERIOD_NS = 50;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
endpackage : xti_pkg

/* xti_tx_port.sv */
// Four-lane double-data-rate transmit input port with lane assembly and code-mode steering.
`timescale 1ns/1ns
// How it works
// (RULE1) Lane A byte is captured on both rising and falling lane A clock edges.
// (RULE2) Coding off: lane ninth bit becomes raw symbol bit eight, passed unencoded.
// (RULE3) Coding on: high lane A ninth bit flags its byte as a K character.
// (RULE4) Lane A tenth bit is raw symbol bit nine when coding off, else ignored.
// (RULE5) Lane sync low: lanes B to D capture on both edges of own clocks.
// (RULE6) Lane sync high: lanes B to D capture on lane A clock edges.
// (RULE7) Lanes B to D ninth bit: K flag when coding on, raw bit eight otherwise.
// (RULE8) Lanes B to D tenth bit: raw bit nine when coding off, else ignored.
// (RULE9) Coding enable high selects encoder path; low selects raw 10-bit symbol path.
// (RULE10) Chip reset low recenters capture state and clears all held outputs.
// (RULE11) Captured lanes assemble into one word A,B,C,D with flags 0 to 3.
module xti_tx_port (
  // Clock and reset
  input  wire logic                                mclk_i,
  input  wire logic                                rst_b_i,
  // Mode pins
  input  wire logic                                coding_enable_i,
  input  wire logic                                lane_sync_select_i,
  // Transmit lanes, index 0 to 3 is lane A to D
  input  wire logic [xti_pkg::LANES-1:0]           lane_tx_clock_i,
  input  wire logic [xti_pkg::LANES*xti_pkg::SYM_W-1:0] lane_tx_sym_i,
  // Assembled coded-path word
  output logic [xti_pkg::WORD_W-1:0]               tx_word_o,
  output logic [xti_pkg::LANES-1:0]                control_char_flag_o,
  // Raw symbol path
  output logic [xti_pkg::LANES*xti_pkg::SYM_W-1:0] raw_sym_o,
  // Qualifiers
  output logic                                     encode_sel_o,
  output logic [xti_pkg::LANES-1:0]                lane_valid_o
);
  import xti_pkg::*;

  // ----------------------------------------
  // Local sizes and limits
  // ----------------------------------------
  // Every pin except rst_b_i, the mode pins included, passes one shared two-stage synchroniser,
  // so mode, clock and data that are seen together were also sampled together.
  // The lane clocks are oversampled by mclk: their half period must stay above two
  // mclk periods, and lane data must hold still for a few mclk cycles around each edge.
  // A capture shows at the outputs three mclk edges after the pin edge, give or take one.
  localparam int PIN_W     = LANES * SYM_W + LANES + 2;
  localparam int CLK_LSB   = LANES * SYM_W;
  localparam int LANE_SYNC_SELECT_POS = PIN_W - 2;
  localparam int CODE_POS  = PIN_W - 1;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Returns which edge, if any, a sampled clock shows.
  function automatic logic [1:0] xti_edge(input logic cur, input logic prev);
    xti_edge = {prev & ~cur, cur & ~prev};
  endfunction : xti_edge

  // Picks the data byte of one lane out of the packed symbol vector.
  function automatic logic [BYTE_W-1:0] xti_byte(input logic [LANES*SYM_W-1:0] sym, input int lane);
    xti_byte = sym[lane*SYM_W +: BYTE_W];
  endfunction : xti_byte

  // Picks the ninth bit of one lane: the control flag, or raw symbol bit eight.
  function automatic logic xti_ninth(input logic [LANES*SYM_W-1:0] sym, input int lane);
    xti_ninth = sym[lane*SYM_W + BIT_NINTH];
  endfunction : xti_ninth

  // Picks the whole ten-bit symbol of one lane.
  function automatic logic [SYM_W-1:0] xti_sym(input logic [LANES*SYM_W-1:0] sym, input int lane);
    xti_sym = sym[lane*SYM_W +: SYM_W];
  endfunction : xti_sym

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  // Reset takes effect at once but is let go on mclk, so no flop leaves reset near an edge.
  logic [1:0] rst_sync_r;
  logic [1:0] rst_sync_nxt;
  logic       rst_n;

  always_comb begin
    rst_sync_nxt = {rst_sync_r[0], 1'b1};
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= rst_sync_nxt;
    end
  end

  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [PIN_W-1:0] meta_r;
  logic [PIN_W-1:0] meta_nxt;
  logic [PIN_W-1:0] sync_r;
  logic [PIN_W-1:0] sync_nxt;
  logic [LANES-1:0] clk_prev_r;
  logic [LANES-1:0] clk_prev_nxt;

  // The third stage on the clocks only remembers the last level for edge finding.
  always_comb begin
    meta_nxt     = {coding_enable_i, lane_sync_select_i, lane_tx_clock_i, lane_tx_sym_i};
    sync_nxt     = meta_r;
    clk_prev_nxt = sync_r[CLK_LSB +: LANES];
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin // see (RULE10)
      meta_r     <= '0;
      sync_r     <= '0;
      clk_prev_r <= '0;
    end else begin
      meta_r     <= meta_nxt;
      sync_r     <= sync_nxt;
      clk_prev_r <= clk_prev_nxt;
    end
  end

  // Synchronised views of the pins.
  logic                   code_s;
  logic                   lane_sync_select_s;
  logic [LANES-1:0]       clk_s;
  logic [LANES*SYM_W-1:0] sym_s;

  assign code_s  = sync_r[CODE_POS];
  assign lane_sync_select_s = sync_r[LANE_SYNC_SELECT_POS];
  assign clk_s   = sync_r[CLK_LSB +: LANES];
  assign sym_s   = sync_r[CLK_LSB-1:0];

  // ----------------------------------------
  // Edge detection and lane clock steering
  // ----------------------------------------
  // Lane A always follows its own clock; lanes B to D follow it too when lane sync is high.
  logic [LANES-1:0] capture;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [1:0] edg;

      always_comb begin
        if (g == 0 || lane_sync_select_s) begin // see (RULE6)
          edg = xti_edge(clk_s[0], clk_prev_r[0]); // see (RULE1)
        end else begin
          edg = xti_edge(clk_s[g], clk_prev_r[g]); // see (RULE5)
        end
        capture[g] = (edg == EDGE_RISE) || (edg == EDGE_FALL);
      end
    end
  endgenerate

  // ----------------------------------------
  // Coded path: byte and control flag per lane
  // ----------------------------------------
  // The tenth bit is dropped here on purpose: in coded mode it carries no meaning.
  logic [WORD_W-1:0] word_r, word_nxt;
  logic [LANES-1:0]  kflag_r, kflag_nxt;

  always_comb begin
    word_nxt  = word_r;
    kflag_nxt = kflag_r;
    for (int i = 0; i < LANES; i++) begin
      if (capture[i] && code_s) begin // see (RULE9)
        word_nxt[i*BYTE_W +: BYTE_W] = xti_byte(sym_s, i); // see (RULE11) see (RULE4) see (RULE8)
        kflag_nxt[i]                 = xti_ninth(sym_s, i); // see (RULE3) see (RULE7)
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin // see (RULE10)
      word_r  <= '0;
      kflag_r <= '0;
    end else begin
      word_r  <= word_nxt;
      kflag_r <= kflag_nxt;
    end
  end

  // ----------------------------------------
  // Raw path: whole ten-bit symbols
  // ----------------------------------------
  // A mode flip leaves the path not in use holding its last value, never half updated.
  logic [LANES*SYM_W-1:0] raw_r, raw_nxt;

  always_comb begin
    raw_nxt = raw_r;
    for (int i = 0; i < LANES; i++) begin
      if (capture[i] && !code_s) begin // see (RULE9)
        raw_nxt[i*SYM_W +: SYM_W] = xti_sym(sym_s, i); // see (RULE2) see (RULE4) see (RULE7) see (RULE8)
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin // see (RULE10)
      raw_r <= '0;
    end else begin
      raw_r <= raw_nxt;
    end
  end

  // ----------------------------------------
  // Qualifiers
  // ----------------------------------------
  logic             enc_r, enc_nxt;
  logic [LANES-1:0] valid_r, valid_nxt;

  always_comb begin
    enc_nxt   = code_s; // see (RULE9)
    valid_nxt = capture;
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin // see (RULE10)
      enc_r   <= 1'b0;
      valid_r <= '0;
    end else begin
      enc_r   <= enc_nxt;
      valid_r <= valid_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign tx_word_o           = word_r;
  assign control_char_flag_o = kflag_r;
  assign raw_sym_o           = raw_r;
  assign encode_sel_o        = enc_r;
  assign lane_valid_o        = valid_r;
endmodule : xti_tx_port

/* xti_tx_port_properties.sv */
// Assertions on the ports of the transmit input port.
`timescale 1ns/1ns
module xti_tx_port_properties (input wire logic mclk_i, rst_b_i, lane_sync_select_i, encode_sel_o,
  input wire logic [3:0] lane_tx_clock_i, control_char_flag_o, lane_valid_o,
  input wire logic [39:0] lane_tx_sym_i, raw_sym_o, input wire logic [31:0] tx_word_o);
  wire [39:0] s = lane_tx_sym_i;
  wire [39:0] r = raw_sym_o;
  wire [3:0]  k = control_char_flag_o;
  wire [3:0]  v = lane_valid_o;
  wire [31:0] w = tx_word_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence cap_a; v[0] && encode_sel_o; endsequence
  AST_A_KFLAG: assert property (cap_a |-> {k[0], w[7:0]} == $past(s[8:0], 4))
    else $error("lane A coded capture wrong");
  AST_A_RAW: assert property (v[0] && !encode_sel_o |-> r[9:0] == $past(s[9:0], 4))
    else $error("lane A raw capture wrong");
  AST_D_RAW: assert property (v[3] && !encode_sel_o |-> r[39:30] == $past(s[39:30], 4))
    else $error("lane D raw capture wrong");
  AST_C_WORD: assert property (v[2] && encode_sel_o |-> {k[2], w[23:16]} == $past(s[28:20], 4))
    else $error("lane C coded capture wrong");
  AST_HOLD: assert property (v[0] && !encode_sel_o |-> $stable(w) && $stable(k))
    else $error("coded outputs moved in raw mode");
  AST_SYNC: assert property (lane_sync_select_i && $past(lane_sync_select_i, 8) |-> v[1] == v[0])
    else $error("lane B not on lane A clock");
  AST_OWN: assert property (v[1] && !lane_sync_select_i |-> $past(lane_tx_clock_i[1], 2) != $past(lane_tx_clock_i[1], 7))
    else $error("lane B capture without own edge");
  AST_RESET: assert property ($rose(rst_b_i) |-> w == 32'h0 && v == 4'h0)
    else $error("outputs not clear after reset");
endmodule : xti_tx_port_properties
bind xti_tx_port xti_tx_port_properties xti_tx_port_properties_i (.*);
